// ### rtl/phy_status_ext_and_bypass_regs.sv
// extended status and bypass control management registers, 0x0F to 0x12
// assumes status inputs come from logic on sys_clk; only the strap is a pin
//
// Behaviour
// (RL1) Registers 0x0B to 0x0E are reserved with no function; they read zero.
// (RL2) Register 15 bits 15 and 14 read 0: no 1000BASE-X capability.
// (RL3) Register 15 bits 13 and 12 read 1; bits 11:0 read zero.
// (RL4) Register 16 bit 15 live descrambler lock, bit 12 live link; reset 0.
// (RL5) Register 16 latches 100BASE-TX error events in bits 14,13,11:8; clear on read.
// (RL6) Register 17 bit 15 live descrambler lock, bit 12 live link; reset 0.
// (RL7) Register 17 latches 1000BASE-T error events in bits 14,13,11:8; clear on read.
// (RL8) Register 17 bit 7 latches carrier extension error, clear on read.
// (RL9) Register 17 bit 5 crossover error, bit 6 legacy partner; read-only, reset 0.
// (RL10) Register 18 bit 15 disables the transmitter; resets 0.
// (RL11) Register 18 bit 7 forces legacy partner detection; resets 0.
// (RL12) Register 18 bit 6 disables legacy partner detection; resets 1.
// (RL13) Register 18 bit 5 disables automatic pair swap correction; resets 0.
// (RL14) Register 18 bit 4 disables polarity correction on all subchannels; resets 0.
// (RL15) Register 18 bit 3 set honours advertised ability in parallel detect; resets 1.
// (RL16) Register 18 bit 1 disables automatic next page exchange; resets 0.
// (RL17) Register 18 bit 0 enables the clock output; reset from configuration strap.
// (RL18) With next pages disabled, stop after base page and hand control to host.
// (RL19) Host then sends next pages, resolves abilities and forces configuration.
// (RL20) Reserved fields read zero and ignore writes.
`timescale 1ns/100ps

module phy_status_ext_and_bypass_regs
  import phy_ext_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic hardware_config_mode,
  input wire mgmt_req_type mgmt_req,
  output logic [15:0] mgmt_rdata,
  output logic mgmt_rvalid,
  input wire fast_status_type fast_status,
  input wire gig_status_type gig_status,
  input wire logic base_page_done,
  output logic transmit_disable,
  output logic tx_test_clock_enable,
  output logic pair_swap_disable,
  output logic polarity_correction_disable,
  output logic parallel_detect_honour,
  output logic auto_next_page_disable,
  output logic auxiliary_clock_output,
  output logic legacy_partner_detected,
  output logic next_page_host_control
);

  regs_type state_reg;
  regs_type state_next;

  // shared layout of both status extension words
  function automatic logic [15:0] status_word(
    input logic lock,
    input logic link,
    input logic [5:0] flags
  );
    logic [15:0] w;
    w = 16'h0000;
    w[LIVE_LOCK_BIT] = lock;
    w[LINK_BIT] = link;
    w[LOCK_ERR_BIT] = flags[5];
    w[DISC_BIT] = flags[4];
    w[RX_ERR_BIT] = flags[3];
    w[TX_ERR_BIT] = flags[2];
    w[SSD_ERR_BIT] = flags[1];
    w[ESD_ERR_BIT] = flags[0];
    return w;
  endfunction

  logic rd_fast;
  logic rd_gig;
  logic [5:0] fast_events;
  logic [6:0] gig_events;
  logic [15:0] gig_word;

  // read strobes that clear the latched flags
  assign rd_fast = mgmt_req.rd && (mgmt_req.addr == ADDR_FAST_STAT);
  assign rd_gig = mgmt_req.rd && (mgmt_req.addr == ADDR_GIG_STAT);
  assign fast_events = {fast_status.lock_err, fast_status.disc, fast_status.rx_err,
                        fast_status.tx_err, fast_status.ssd_err, fast_status.esd_err};
  assign gig_events = {gig_status.lock_err, gig_status.disc, gig_status.rx_err,
                       gig_status.tx_err, gig_status.ssd_err, gig_status.esd_err,
                       gig_status.cext_err};

  // gigabit word: shared layout plus the extra low fields
  always_comb begin
    gig_word = status_word(gig_status.lock, gig_status.link, state_reg.gig_flags[6:1]); // RL6
    gig_word[CEXT_ERR_BIT] = state_reg.gig_flags[0]; // RL8
    gig_word[LEGACY_BIT] = state_reg.legacy; // RL9
    gig_word[XOVER_ERR_BIT] = gig_status.xover_err; // RL9
  end

  // next state of the whole register bank
  always_comb begin
    state_next = state_reg;
    state_next.rvalid = mgmt_req.rd;
    state_next.strap_meta = hardware_config_mode;
    state_next.strap_sync = state_reg.strap_meta;

    // strap is caught only once the synchroniser has filled after release
    case (state_reg.phase)
      PH_STRAP_WAIT1: begin
        state_next.phase = PH_STRAP_WAIT2;
      end
      PH_STRAP_WAIT2: begin
        state_next.phase = PH_STRAP_LOAD;
      end
      PH_STRAP_LOAD: begin
        state_next.phase = PH_RUN;
        state_next.bypass[BYP_AUX_CLK_EN] = state_reg.strap_sync; // RL17
      end
      PH_RUN: begin
        state_next.phase = PH_RUN;
      end
      default: begin
        state_next.phase = PH_RUN;
      end
    endcase

    // only the documented bits take writes, reserved bits stay zero
    if (mgmt_req.wr && (mgmt_req.addr == ADDR_BYPASS)) begin
      state_next.bypass = mgmt_req.wdata & BYPASS_WRITE_MASK; // RL10 RL20
    end

    // set wins over clear-on-read, so no event is lost
    state_next.fast_flags = (state_reg.fast_flags & ~{6{rd_fast}}) | fast_events; // RL5
    state_next.gig_flags = (state_reg.gig_flags & ~{7{rd_gig}}) | gig_events; // RL7 RL8

    // force beats disable; disable masks the raw detector
    state_next.legacy = state_reg.bypass[BYP_LEGACY_FORCE] // RL11
      | (gig_status.legacy_seen & ~state_reg.bypass[BYP_LEGACY_DIS]); // RL12

    // hand-off after base page when the host runs the next pages
    if (!state_reg.bypass[BYP_AUTO_NP_DIS]) begin
      state_next.np_host = 1'b0;
    end else if (base_page_done) begin
      state_next.np_host = 1'b1; // RL18
    end

    // read answer, registered one cycle after the strobe
    state_next.rdata = 16'h0000; // RL1 RL20
    if (mgmt_req.rd) begin
      case (mgmt_req.addr)
        ADDR_GIG_CAP: state_next.rdata = GIG_CAP_VALUE; // RL2 RL3
        ADDR_FAST_STAT: begin
          state_next.rdata = status_word(fast_status.lock, fast_status.link,
                                         state_reg.fast_flags); // RL4 RL5
        end
        ADDR_GIG_STAT: state_next.rdata = gig_word; // RL7
        ADDR_BYPASS: state_next.rdata = state_reg.bypass;
        default: state_next.rdata = 16'h0000; // RL1
      endcase
    end
  end

  // single register for all state; reset is synchronous
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_reg.phase <= PH_STRAP_WAIT1;
      state_reg.strap_meta <= 1'b0;
      state_reg.strap_sync <= 1'b0;
      state_reg.bypass <= BYPASS_RESET; // RL12 RL15
      state_reg.fast_flags <= 6'h00;
      state_reg.gig_flags <= 7'h00;
      state_reg.legacy <= 1'b0;
      state_reg.np_host <= 1'b0;
      state_reg.rdata <= 16'h0000;
      state_reg.rvalid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // control outputs straight from the bypass register; legacy view, hand-off flag and read port from their own registers
  assign transmit_disable = state_reg.bypass[BYP_TX_DISABLE]; // RL10
  assign tx_test_clock_enable = state_reg.bypass[BYP_TEST_CLK];
  assign pair_swap_disable = state_reg.bypass[BYP_PAIR_SWAP_DIS]; // RL13
  assign polarity_correction_disable = state_reg.bypass[BYP_POL_DIS]; // RL14
  assign parallel_detect_honour = state_reg.bypass[BYP_PAR_DET]; // RL15
  assign auto_next_page_disable = state_reg.bypass[BYP_AUTO_NP_DIS]; // RL16
  assign auxiliary_clock_output = state_reg.bypass[BYP_AUX_CLK_EN]; // RL17
  assign legacy_partner_detected = state_reg.legacy;
  assign next_page_host_control = state_reg.np_host;
  assign mgmt_rdata = state_reg.rdata;
  assign mgmt_rvalid = state_reg.rvalid;

  // checks on the register bank
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  rsvd_read_zero_a: assert property ( // RL1
    mgmt_req.rd && mgmt_req.addr >= ADDR_RSVD_FIRST && mgmt_req.addr <= ADDR_RSVD_LAST
    |=> mgmt_rvalid && mgmt_rdata == 16'h0000)
    else $error("reserved address did not read zero");

  gig_cap_x_a: assert property ( // RL2
    mgmt_req.rd && mgmt_req.addr == ADDR_GIG_CAP |=> mgmt_rdata[15:14] == 2'b00)
    else $error("1000BASE-X capability bits not zero");

  gig_cap_t_a: assert property ( // RL3
    mgmt_req.rd && mgmt_req.addr == ADDR_GIG_CAP
    |=> mgmt_rdata[13:12] == 2'b11 && mgmt_rdata[11:0] == 12'h000)
    else $error("1000BASE-T capability word wrong");

  fast_live_a: assert property ( // RL4
    rd_fast |=> mgmt_rdata[15] == $past(fast_status.lock)
             && mgmt_rdata[12] == $past(fast_status.link))
    else $error("fast status live bits wrong");

  fast_sticky_a: assert property ( // RL5
    fast_status.rx_err |=> state_reg.fast_flags[3])
    else $error("fast receive error not latched");

  fast_report_a: assert property ( // RL5
    fast_status.rx_err ##1 !rd_fast ##1 rd_fast |=> mgmt_rdata[RX_ERR_BIT])
    else $error("fast receive error not reported");

  fast_clear_a: assert property ( // RL5
    rd_fast && fast_events == 6'h00 ##1 !fast_status.disc |-> state_reg.fast_flags[4] == 1'b0)
    else $error("fast flags not cleared by read");

  gig_live_a: assert property ( // RL6
    rd_gig |=> mgmt_rdata[15] == $past(gig_status.lock) && mgmt_rdata[12] == $past(gig_status.link))
    else $error("gigabit status live bits wrong");

  gig_flag_a: assert property ( // RL7
    gig_status.disc && rd_gig |=> state_reg.gig_flags[5])
    else $error("gigabit event lost against read clear");

  cext_flag_a: assert property ( // RL8
    gig_status.cext_err ##1 !rd_gig ##1 rd_gig |=> mgmt_rdata[CEXT_ERR_BIT])
    else $error("carrier extension error not reported");

  legacy_view_a: assert property ( // RL9
    ##1 legacy_partner_detected == ($past(state_reg.bypass[BYP_LEGACY_FORCE])
      | ($past(gig_status.legacy_seen) & ~$past(state_reg.bypass[BYP_LEGACY_DIS]))))
    else $error("legacy partner view wrong");

  tx_disable_a: assert property ( // RL10
    mgmt_req.wr && mgmt_req.addr == ADDR_BYPASS |=> transmit_disable == $past(mgmt_req.wdata[15])
      && auto_next_page_disable == $past(mgmt_req.wdata[1]))
    else $error("bypass control write not applied");

  bypass_reset_a: assert property ( // RL12
    state_reg.phase == PH_STRAP_WAIT1 |-> state_reg.bypass[7:3] == 5'b01001)
    else $error("bypass control reset value wrong");

  strap_load_a: assert property ( // RL17
    state_reg.phase == PH_STRAP_LOAD |=> auxiliary_clock_output == $past(state_reg.strap_sync))
    else $error("clock output enable not taken from strap");

  np_hold_a: assert property ( // RL18
    base_page_done && auto_next_page_disable |=> next_page_host_control[*2]
      or !auto_next_page_disable)
    else $error("no hand-off after base page");

  rsvd_write_a: assert property ( // RL20
    ##1 (state_reg.bypass & ~BYPASS_WRITE_MASK) == 16'h0000)
    else $error("reserved bypass bit set");

  fast_set_a: assert property ( // RL5
    fast_status.esd_err |=> state_reg.fast_flags[0])
    else $error("fast delimiter error not latched");

  gig_clear_a: assert property ( // RL7
    rd_gig && gig_events == 7'h00 |=> state_reg.gig_flags == 7'h00)
    else $error("gigabit flags not cleared by read");

  // sticky control bits move only on a write once the strap has landed
  bypass_hold_a: assert property ( // RL10
    state_reg.phase == PH_RUN && !(mgmt_req.wr && mgmt_req.addr == ADDR_BYPASS)
    |=> $stable(state_reg.bypass))
    else $error("bypass control changed without a write");

  legacy_force_a: assert property ( // RL11
    state_reg.bypass[BYP_LEGACY_FORCE] |=> legacy_partner_detected)
    else $error("forced legacy detection not shown");

  legacy_mask_a: assert property ( // RL12
    state_reg.bypass[BYP_LEGACY_DIS] && !state_reg.bypass[BYP_LEGACY_FORCE]
    |=> !legacy_partner_detected)
    else $error("disabled legacy detection still shown");

  pair_swap_a: assert property ( // RL13 RL14
    mgmt_req.wr && mgmt_req.addr == ADDR_BYPASS
    |=> pair_swap_disable == $past(mgmt_req.wdata[BYP_PAIR_SWAP_DIS])
      && polarity_correction_disable == $past(mgmt_req.wdata[BYP_POL_DIS]))
    else $error("correction disable bits not applied");

  par_detect_a: assert property ( // RL15
    mgmt_req.wr && mgmt_req.addr == ADDR_BYPASS
    |=> parallel_detect_honour == $past(mgmt_req.wdata[BYP_PAR_DET])
      && auxiliary_clock_output == $past(mgmt_req.wdata[BYP_AUX_CLK_EN]))
    else $error("parallel detect or clock output bit not applied");

  np_release_a: assert property ( // RL18
    !auto_next_page_disable |=> !next_page_host_control)
    else $error("host hand-off without disabled next pages");

  read_fast_c: cover property (fast_status.ssd_err ##2 rd_fast ##1 mgmt_rdata[SSD_ERR_BIT]);
  clear_race_c: cover property (rd_gig && gig_status.rx_err);
  np_handoff_c: cover property (auto_next_page_disable && base_page_done ##1 next_page_host_control);
  legacy_force_c: cover property (state_reg.bypass[BYP_LEGACY_FORCE] ##1 legacy_partner_detected);
  strap_low_c: cover property (state_reg.phase == PH_STRAP_LOAD && !state_reg.strap_sync);

endmodule

// ### common/phy_ext_pkg.sv
// package for the extended status and bypass management registers
// assumes a 16-bit management register space addressed by 5-bit register numbers
package phy_ext_pkg;

  // register numbers
  localparam logic [4:0] ADDR_RSVD_FIRST = 5'h0B;
  localparam logic [4:0] ADDR_RSVD_LAST = 5'h0E;
  localparam logic [4:0] ADDR_GIG_CAP = 5'h0F;
  localparam logic [4:0] ADDR_FAST_STAT = 5'h10;
  localparam logic [4:0] ADDR_GIG_STAT = 5'h11;
  localparam logic [4:0] ADDR_BYPASS = 5'h12;

  // capability word: 1000BASE-X fdx/hdx = 0, 1000BASE-T fdx/hdx = 1, rest 0
  localparam logic [15:0] GIG_CAP_VALUE = 16'h3000;

  // status extension field positions
  localparam int LIVE_LOCK_BIT = 15;
  localparam int LOCK_ERR_BIT = 14;
  localparam int DISC_BIT = 13;
  localparam int LINK_BIT = 12;
  localparam int RX_ERR_BIT = 11;
  localparam int TX_ERR_BIT = 10;
  localparam int SSD_ERR_BIT = 9;
  localparam int ESD_ERR_BIT = 8;
  localparam int CEXT_ERR_BIT = 7;
  localparam int LEGACY_BIT = 6;
  localparam int XOVER_ERR_BIT = 5;

  // bypass control field positions
  localparam int BYP_TX_DISABLE = 15;
  localparam int BYP_TEST_CLK = 8;
  localparam int BYP_LEGACY_FORCE = 7;
  localparam int BYP_LEGACY_DIS = 6;
  localparam int BYP_PAIR_SWAP_DIS = 5;
  localparam int BYP_POL_DIS = 4;
  localparam int BYP_PAR_DET = 3;
  localparam int BYP_AUTO_NP_DIS = 1;
  localparam int BYP_AUX_CLK_EN = 0;

  // writable bits and reset value of bypass control (bit 0 comes from the strap)
  localparam logic [15:0] BYPASS_WRITE_MASK = 16'h81FB;
  localparam logic [15:0] BYPASS_RESET = 16'h0048;

  typedef enum logic [3:0] {
    PH_STRAP_WAIT1 = 4'b0001,
    PH_STRAP_WAIT2 = 4'b0010,
    PH_STRAP_LOAD = 4'b0100,
    PH_RUN = 4'b1000
  } phase_type;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [4:0] addr;
    logic [15:0] wdata;
  } mgmt_req_type;

  typedef struct packed {
    logic lock;
    logic link;
    logic lock_err;
    logic disc;
    logic rx_err;
    logic tx_err;
    logic ssd_err;
    logic esd_err;
  } fast_status_type;

  typedef struct packed {
    logic lock;
    logic link;
    logic lock_err;
    logic disc;
    logic rx_err;
    logic tx_err;
    logic ssd_err;
    logic esd_err;
    logic cext_err;
    logic xover_err;
    logic legacy_seen;
  } gig_status_type;

  typedef struct packed {
    phase_type phase;
    logic strap_meta;
    logic strap_sync;
    logic [15:0] bypass;
    logic [5:0] fast_flags;
    logic [6:0] gig_flags;
    logic legacy;
    logic np_host;
    logic [15:0] rdata;
    logic rvalid;
  } regs_type;

endpackage

// ### dv/mgmt_host_model.sv
// station management host model driving the register port of the status block
// assumes one access at a time, one-cycle strobes and an answer within four cycles
`timescale 1ns/100ps

module mgmt_host_model
  import phy_ext_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [15:0] mgmt_rdata,
  input wire logic mgmt_rvalid,
  output mgmt_req_type mgmt_req
);

  // idle port until the first access
  initial begin
    mgmt_req = '0;
  end

  // one-cycle read strobe, then a bounded wait; no answer leaves the word unknown
  task automatic read(input logic [4:0] a, output logic [15:0] d);
    d = 'x;
    @(posedge sys_clk);
    mgmt_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge sys_clk);
    mgmt_req <= '0;
    for (int n = 0; n < 4; n++) begin
      @(posedge sys_clk);
      if (mgmt_rvalid === 1'b1) begin
        d = mgmt_rdata;
        break;
      end
    end
  endtask

  // one-cycle write strobe; also how the host forces the resolved configuration
  task automatic write(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    mgmt_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge sys_clk);
    mgmt_req <= '0;
  endtask

endmodule

// ### dv/tb.sv
// top-level bench for the extended status and bypass management registers
// assumes the host model owns the register port; the bench drives status and strap
`timescale 1ns/100ps

module tb
  import phy_ext_pkg::*;
;
  logic sys_clk;
  logic reset_n;
  logic hardware_config_mode;
  mgmt_req_type mgmt_req;
  logic [15:0] mgmt_rdata;
  logic mgmt_rvalid;
  fast_status_type fast_status;
  gig_status_type gig_status;
  logic base_page_done;
  logic [7:0] outs;
  logic np_ctl;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  int pos[7] = '{7, 8, 9, 10, 11, 13, 14};

  phy_status_ext_and_bypass_regs i_phy_status_ext_and_bypass_regs (
    .sys_clk(sys_clk), .reset_n(reset_n), .hardware_config_mode(hardware_config_mode),
    .mgmt_req(mgmt_req), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .fast_status(fast_status), .gig_status(gig_status), .base_page_done(base_page_done),
    .transmit_disable(outs[7]), .tx_test_clock_enable(outs[6]),
    .pair_swap_disable(outs[5]), .polarity_correction_disable(outs[4]),
    .parallel_detect_honour(outs[3]), .auto_next_page_disable(outs[2]),
    .auxiliary_clock_output(outs[1]), .legacy_partner_detected(outs[0]),
    .next_page_host_control(np_ctl)
  );

  mgmt_host_model i_mgmt_host_model (
    .sys_clk(sys_clk), .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid),
    .mgmt_req(mgmt_req)
  );

  // free-running clock, 8 ns period
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    i_mgmt_host_model.read(a, d);
    chk($sformatf("register %h", a), exp, d);
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    i_mgmt_host_model.write(a, d);
  endtask

  // legacy view is registered from the bypass word, so it needs a second edge
  task automatic out_chk(input logic [7:0] exp);
    repeat (2) @(posedge sys_clk);
    chk("control outputs", {8'h00, exp}, {8'h00, outs});
  endtask

  // one-cycle hand-off pulse, then look at the registered flag
  task automatic np_chk(input logic exp);
    base_page_done <= 1'b1;
    @(posedge sys_clk);
    base_page_done <= 1'b0;
    @(posedge sys_clk);
    chk("next page host control", {15'h0000, exp}, {15'h0000, np_ctl});
  endtask

  // hang guard; a normal run needs well under a thousand cycles
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test;
    end
  end

  initial begin
    reset_n = 1'b0;
    hardware_config_mode = 1'b1;
    fast_status = '0;
    gig_status = '0;
    base_page_done = 1'b0;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    // strap needs three edges to land in bit 0
    repeat (3) @(posedge sys_clk);
    rd_chk(ADDR_BYPASS, 16'h0049);
    out_chk(8'h0A);
    rd_chk(ADDR_GIG_CAP, 16'h3000);
    wr(ADDR_GIG_CAP, 16'hFFFF);
    rd_chk(ADDR_GIG_CAP, 16'h3000);
    for (int a = ADDR_RSVD_FIRST; a <= ADDR_RSVD_LAST; a++) begin
      wr(5'(a), 16'hFFFF);
      rd_chk(5'(a), 16'h0000);
    end
    rd_chk(ADDR_FAST_STAT, 16'h0000);
    rd_chk(ADDR_GIG_STAT, 16'h0000);
    // every writable bit at once, then reserved bits must read back zero
    wr(ADDR_BYPASS, 16'hFFFF);
    out_chk(8'hFF);
    rd_chk(ADDR_BYPASS, 16'h81FB);
    wr(ADDR_BYPASS, 16'h0000);
    out_chk(8'h00);
    // raw legacy detector high: disabled, then enabled
    gig_status <= 11'h603;
    fast_status <= 8'hC0;
    wr(ADDR_BYPASS, 16'h0040);
    out_chk(8'h00);
    rd_chk(ADDR_GIG_STAT, 16'h9020);
    wr(ADDR_BYPASS, 16'h0000);
    out_chk(8'h01);
    rd_chk(ADDR_GIG_STAT, 16'h9060);
    gig_status <= 11'h602;
    wr(ADDR_BYPASS, 16'h0048);
    rd_chk(ADDR_FAST_STAT, 16'h9000);
    // one event at a time so a swapped bit shows up
    for (int i = 0; i < 7; i++) begin
      gig_status <= 11'h602 | (11'h004 << i);
      @(posedge sys_clk);
      gig_status <= 11'h602;
      rd_chk(ADDR_GIG_STAT, 16'h9020 | (16'h0001 << pos[i]));
      rd_chk(ADDR_GIG_STAT, 16'h9020);
    end
    // events still standing while the register is read: the set must win
    gig_status <= 11'h6C2;
    rd_chk(ADDR_GIG_STAT, 16'hB820);
    gig_status <= 11'h602;
    rd_chk(ADDR_GIG_STAT, 16'hB820);
    rd_chk(ADDR_GIG_STAT, 16'h9020);
    for (int i = 0; i < 6; i++) begin
      fast_status <= 8'hC0 | (8'h01 << i);
      @(posedge sys_clk);
      fast_status <= 8'hC0;
      rd_chk(ADDR_FAST_STAT, 16'h9000 | (16'h0001 << pos[i + 1]));
      rd_chk(ADDR_FAST_STAT, 16'h9000);
    end
    fast_status <= 8'h00;
    rd_chk(ADDR_FAST_STAT, 16'h0000);
    np_chk(1'b0);
    wr(ADDR_BYPASS, 16'h004A);
    np_chk(1'b1);
    // host takes back the pages and restores automatic exchange
    wr(ADDR_BYPASS, 16'h0048);
    repeat (2) @(posedge sys_clk);
    chk("next page release", 16'h0000, {15'h0000, np_ctl});
    // second reset with the strap low: clock output must come up disabled
    hardware_config_mode <= 1'b0;
    reset_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rd_chk(ADDR_BYPASS, 16'h0048);
    out_chk(8'h08);
    end_of_test;
  end

endmodule
